// ### pkg/pmam_pkg.sv
// constants and carrier types for the alert-mask bank
package pmam_pkg;
  // command code of the alert mask command
  localparam logic [7:0] PMAM_CMD_ALERT_MASK = 8'h1b;
  // phase value meaning all phases
  localparam logic [7:0] PMAM_PHASE_ALL = 8'hff;
  // selector codes, one per status class
  localparam logic [7:0] PMAM_SEL_VOUT = 8'h7a;
  localparam logic [7:0] PMAM_SEL_IOUT = 8'h7b;
  localparam logic [7:0] PMAM_SEL_INPUT = 8'h7c;
  localparam logic [7:0] PMAM_SEL_TEMP = 8'h7d;
  localparam logic [7:0] PMAM_SEL_CML = 8'h7e;
  localparam int PMAM_NCLASS = 5;
  // class index, counted from the vout selector
  localparam logic [2:0] PMAM_IDX_VOUT = 3'h0;
  localparam logic [2:0] PMAM_IDX_IOUT = 3'h1;
  localparam logic [2:0] PMAM_IDX_INPUT = 3'h2;
  localparam logic [2:0] PMAM_IDX_TEMP = 3'h3;
  localparam logic [2:0] PMAM_IDX_CML = 3'h4;
  // writable bits of each mask byte; others read zero
  localparam logic [7:0] PMAM_WR_VOUT = 8'hfc;
  localparam logic [7:0] PMAM_WR_IOUT = 8'hb0;
  localparam logic [7:0] PMAM_WR_INPUT = 8'h08;
  localparam logic [7:0] PMAM_WR_TEMP = 8'hc0;
  localparam logic [7:0] PMAM_WR_CML = 8'hf2;
  // mask bit positions
  localparam int PMAM_B_OVP_FAULT = 7;
  localparam int PMAM_B_OVP_WARN = 6;
  localparam int PMAM_B_UVP_WARN = 5;
  localparam int PMAM_B_UVP_FAULT = 4;
  localparam int PMAM_B_VOUT_LIMIT = 3;
  localparam int PMAM_B_TON_TIMEOUT = 2;
  localparam int PMAM_B_OC_FAULT = 7;
  localparam int PMAM_B_OC_WARN = 5;
  localparam int PMAM_B_UC_FAULT = 4;
  localparam int PMAM_B_LOW_INPUT = 3;
  localparam int PMAM_B_OT_FAULT = 7;
  localparam int PMAM_B_OT_WARN = 6;
  localparam int PMAM_B_BAD_CMD = 7;
  localparam int PMAM_B_BAD_PAYLOAD = 6;
  localparam int PMAM_B_PACKET_CHECK = 5;
  localparam int PMAM_B_MEM_FAULT = 4;
  localparam int PMAM_B_OTHER_COMM = 1;
  // reset value before the nonvolatile load arrives
  localparam logic [7:0] PMAM_MASK_RST = 8'h00;
  // one byte per class, index 0 = vout
  typedef logic [PMAM_NCLASS-1:0][7:0] pmam_bank_t;
  localparam pmam_bank_t PMAM_WR_BITS = {PMAM_WR_CML, PMAM_WR_TEMP, PMAM_WR_INPUT,
                                         PMAM_WR_IOUT, PMAM_WR_VOUT};
  // decoded word write: command, low byte (selector), high byte (mask)
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] low;
    logic [7:0] high;
  } pmam_word_s;
  // decoded block-write/block-read process call: command, one-byte block
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] sel;
  } pmam_call_s;
endpackage

// ### logic/pmam_top.sv
// alert-mask bank: per-class mask bytes gating status onto the shared alert line
// What this block does
// - mask 0 lets condition alert, 1 blocks
// - masking never alters the status bits
// - word write 1Bh: low selects, high value
// - one-byte block select returns one-byte mask
// - updates only by word write to 1Bh or by nvm_load
// - reads by process call, one unsigned byte
// - access only while phase is FFh
// - reset from nonvolatile (rst_b clears masks to 00h; nvm_bank loads only on nvm_load), writes act immediately
// - vout mask bits 7:2 writable, 1:0 zero
// - iout mask 7Bh bits 7,5,4 writable
// - input mask 7Ch only bit 3 writable
// - temperature mask 7Dh bits 7,6 writable
// - cml mask 7Eh bits 7,6,5,4,1 writable
`timescale 1ns/100ps
module pmam_top
  import pmam_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic clk_en,
  input wire logic [7:0] phase,
  input wire logic wr_valid,
  input wire pmam_pkg::pmam_word_s wr_word,
  input wire logic rd_valid,
  input wire pmam_pkg::pmam_call_s rd_call,
  input wire logic nvm_load,
  input wire pmam_pkg::pmam_bank_t nvm_bank,
  input wire pmam_pkg::pmam_bank_t status_bank,
  output logic wr_done,
  output logic wr_err,
  output logic rd_ack,
  output logic rd_err,
  output logic [7:0] rd_data,
  output pmam_pkg::pmam_bank_t mask_bank,
  output logic alert_n_o,
  output logic alert_n_oe
);
  pmam_bank_t bank_q;
  logic [7:0] wr_off;
  logic [7:0] rd_off;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;
  logic wr_ok;
  logic rd_ok;
  logic wr_done_q;
  logic wr_err_q;
  logic rd_ack_q;
  logic rd_err_q;
  logic [7:0] rd_data_q;
  logic alert_q;
  logic alert_d;

  // selector decode; out-of-range selectors are refused
  assign wr_off = wr_word.low - PMAM_SEL_VOUT;
  assign rd_off = rd_call.sel - PMAM_SEL_VOUT;
  assign wr_idx = wr_off[2:0];
  assign rd_idx = rd_off[2:0];
  assign wr_ok = wr_valid && (wr_word.cmd == PMAM_CMD_ALERT_MASK)
                 && (phase == PMAM_PHASE_ALL)
                 && (wr_word.low >= PMAM_SEL_VOUT) && (wr_word.low <= PMAM_SEL_CML);
  assign rd_ok = rd_valid && (rd_call.cmd == PMAM_CMD_ALERT_MASK)
                 && (phase == PMAM_PHASE_ALL)
                 && (rd_call.sel >= PMAM_SEL_VOUT) && (rd_call.sel <= PMAM_SEL_CML);

  // one mask byte per class; read-only bits are never stored, so they read zero
  for (genvar i = 0; i < PMAM_NCLASS; i++) begin : g_class
    always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
        bank_q[i] <= PMAM_MASK_RST;
      end else if (clk_en) begin
        if (nvm_load) begin
          bank_q[i] <= nvm_bank[i] & PMAM_WR_BITS[i];
        end else if (wr_ok && (wr_idx == 3'(i))) begin
          bank_q[i] <= wr_word.high & PMAM_WR_BITS[i];
        end
      end
    end
    property p_ro_zero;
      @(posedge mclk) disable iff (!rst_b)
        (bank_q[i] & ~PMAM_WR_BITS[i]) == 8'h00;
    endproperty
    a_ro_zero: assert property (p_ro_zero) else $error("read-only mask bit set");
  end

  // write outcome pulses
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wr_done_q <= 1'b0;
      wr_err_q <= 1'b0;
    end else if (clk_en) begin
      wr_done_q <= wr_ok && !nvm_load;
      wr_err_q <= wr_valid && !wr_ok;
    end
  end

  // process-call read answer, one cycle after the request
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rd_ack_q <= 1'b0;
      rd_err_q <= 1'b0;
      rd_data_q <= 8'h00;
    end else if (clk_en) begin
      rd_ack_q <= rd_ok;
      rd_err_q <= rd_valid && !rd_ok;
      if (rd_ok) begin
        rd_data_q <= bank_q[rd_idx];
      end
    end
  end

  // status is only read here, never written back, so masking leaves it intact
  always_comb begin
    alert_d = 1'b0;
    for (int k = 0; k < PMAM_NCLASS; k++) begin
      alert_d = alert_d | (|(status_bank[k] & ~bank_q[k]));
    end
  end

  // registered so the open-drain pin never glitches on status skew
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      alert_q <= 1'b0;
    end else if (clk_en) begin
      alert_q <= alert_d;
    end
  end

  assign wr_done = wr_done_q;
  assign wr_err = wr_err_q;
  assign rd_ack = rd_ack_q;
  assign rd_err = rd_err_q;
  assign rd_data = rd_data_q;
  assign mask_bank = bank_q;
  assign alert_n_o = 1'b0;
  assign alert_n_oe = alert_q;

  // rst_b in the antecedent: at the release edge the pin flop is still held clear
  property p_alert_on;
    @(posedge mclk) disable iff (!rst_b)
      rst_b && clk_en && alert_d |=> alert_n_oe;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("unmasked status did not alert");

  property p_all_masked;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && ((status_bank & ~bank_q) == '0) |=> !alert_n_oe;
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("masked status drove alert");

  property p_write_lands;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && wr_ok && !nvm_load |=>
        bank_q[$past(wr_idx)] == ($past(wr_word.high) & PMAM_WR_BITS[$past(wr_idx)]);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("mask write not applied");

  property p_write_live;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && wr_ok && !nvm_load ##1 clk_en |=> alert_n_oe == $past(alert_d);
  endproperty
  a_write_live: assert property (p_write_live) else $error("new mask not in effect");

  property p_phase_block;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && wr_valid && (phase != PMAM_PHASE_ALL) && !nvm_load |=> $stable(bank_q) && wr_err;
  endproperty
  a_phase_block: assert property (p_phase_block) else $error("write taken at wrong phase");

  property p_cmd_only;
    @(posedge mclk) disable iff (!rst_b)
      !nvm_load && !(wr_valid && wr_word.cmd == PMAM_CMD_ALERT_MASK) |=> $stable(bank_q);
  endproperty
  a_cmd_only: assert property (p_cmd_only) else $error("mask changed without write");

  property p_read_back;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && rd_ok |=> rd_ack && (rd_data == $past(bank_q[rd_idx]));
  endproperty
  a_read_back: assert property (p_read_back) else $error("read returned wrong mask");

  property p_read_refuse;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && rd_valid && !rd_ok |=> rd_err && !rd_ack;
  endproperty
  a_read_refuse: assert property (p_read_refuse) else $error("bad read not refused");

  property p_nvm_load;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && nvm_load |=> bank_q == ($past(nvm_bank) & PMAM_WR_BITS);
  endproperty
  a_nvm_load: assert property (p_nvm_load) else $error("nonvolatile defaults not loaded");

  // answers stay quiet without a request, and a refusal never reports success
  property p_wr_idle;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && !wr_valid |=> !wr_done && !wr_err;
  endproperty
  a_wr_idle: assert property (p_wr_idle) else $error("write answer without request");

  property p_wr_refuse;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && wr_valid && !wr_ok |=> wr_err && !wr_done;
  endproperty
  a_wr_refuse: assert property (p_wr_refuse) else $error("bad write not refused");

  // a same-cycle nonvolatile load takes priority, so the write is silently lost
  property p_nvm_wins;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && nvm_load |=> !wr_done;
  endproperty
  a_nvm_wins: assert property (p_nvm_wins) else $error("write reported during load");

  property p_rd_hold;
    @(posedge mclk) disable iff (!rst_b)
      clk_en && !rd_ok |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");

  // enable low must freeze masks, read data and the alert pin alike
  property p_frozen;
    @(posedge mclk) disable iff (!rst_b)
      !clk_en |=> $stable(bank_q) && $stable(rd_data) && $stable(alert_n_oe);
  endproperty
  a_frozen: assert property (p_frozen) else $error("state moved while enable low");
endmodule

// ### verif/pmam_host.sv
// host-side model issuing decoded mask writes and mask reads
`timescale 1ns/100ps
module pmam_host
  import pmam_pkg::*;
(
  input wire logic mclk,
  output logic wr_valid,
  output pmam_pkg::pmam_word_s wr_word,
  output logic rd_valid,
  output pmam_pkg::pmam_call_s rd_call
);
  initial begin
    wr_valid = 1'b0;
    rd_valid = 1'b0;
    wr_word = '0;
    rd_call = '0;
  end
  // word write: low byte selects, high byte is the mask
  task automatic wr(input logic [7:0] c, input logic [7:0] s, input logic [7:0] v);
    @(posedge mclk);
    wr_valid <= 1'b1;
    wr_word <= '{c, s, v};
    @(posedge mclk);
    wr_valid <= 1'b0;
    wr_word <= ~{c, s, v}; // released bytes must not look stale
    #1;
  endtask
  // one-byte block select, one-byte block back
  task automatic rd(input logic [7:0] c, input logic [7:0] s);
    @(posedge mclk);
    rd_valid <= 1'b1;
    rd_call <= '{c, s};
    @(posedge mclk);
    rd_valid <= 1'b0;
    rd_call <= ~{c, s};
    #1;
  endtask
endmodule

// ### verif/tb_top.sv
// self-checking bench for the alert-mask bank
`timescale 1ns/100ps
module tb_top;
  import pmam_pkg::*;
  logic mclk, rst_b, clk_en, nvm_load, wr_valid, rd_valid, wr_done, wr_err;
  logic rd_ack, rd_err, alert_n_o, alert_n_oe;
  logic [7:0] phase, rd_data, v, s;
  pmam_word_s wr_word;
  pmam_call_s rd_call;
  pmam_bank_t nvm_bank, status_bank, mask_bank, em;
  int n_errors = 0;
  int checked = 0;
  // writable bits per class, vout first
  logic [7:0] wm [5] = '{8'hfc, 8'hb0, 8'h08, 8'hc0, 8'hf2};
  pmam_top i_pmam_top(.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en), .phase(phase),
    .wr_valid(wr_valid), .wr_word(wr_word), .rd_valid(rd_valid), .rd_call(rd_call),
    .nvm_load(nvm_load), .nvm_bank(nvm_bank), .status_bank(status_bank),
    .wr_done(wr_done), .wr_err(wr_err), .rd_ack(rd_ack), .rd_err(rd_err),
    .rd_data(rd_data), .mask_bank(mask_bank), .alert_n_o(alert_n_o),
    .alert_n_oe(alert_n_oe));
  pmam_host i_pmam_host(.mclk(mclk), .wr_valid(wr_valid), .wr_word(wr_word),
    .rd_valid(rd_valid), .rd_call(rd_call));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // alert wanted while any unmasked status bit is set
  function automatic logic exp_alert(input pmam_bank_t st, input pmam_bank_t mk);
    return |(st & ~mk);
  endfunction
  task automatic stop_test();
    $display("counts: %0d checked, %0d mismatches", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    phase = 8'hff;
    nvm_load = 1'b0;
    nvm_bank = '0;
    status_bank = '0;
    void'($urandom(38176));
    repeat (6) @(posedge mclk);
    rst_b <= 1'b1;
    // defaults come from the nonvolatile bank, writable bits only
    @(posedge mclk);
    nvm_bank <= {8'($urandom), 32'($urandom)};
    nvm_load <= 1'b1;
    @(posedge mclk);
    nvm_load <= 1'b0;
    #1;
    for (int i = 0; i < 5; i++) begin
      em[i] = nvm_bank[i] & wm[i];
      chk("nvm mask", em[i], mask_bank[i]);
    end
    $display("test nvm load done");
    // write then read back each class; first write sets read-only bits too
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 8'hff : 8'($urandom);
      s = 8'(8'h7a + i);
      i_pmam_host.wr(8'h1b, s, v);
      em[i] = v & wm[i];
      chk("wr_done", 8'h01, {7'h0, wr_done});
      chk("mask", em[i], mask_bank[i]);
      i_pmam_host.rd(8'h1b, s);
      chk("rd_ack", 8'h01, {7'h0, rd_ack});
      chk("rd_data", em[i], rd_data);
    end
    $display("test class access done");
    // wrong command, wrong phase, selectors outside the bank
    for (int k = 0; k < 4; k++) begin
      phase <= (k == 1) ? 8'hfe : 8'hff;
      s = (k == 2) ? 8'h7f : (k == 3) ? 8'h79 : 8'h7b;
      i_pmam_host.wr((k == 0) ? 8'h1c : 8'h1b, s, ~em[1]);
      chk("wr_err", 8'h01, {7'h0, wr_err});
      chk("mask kept", em[1], mask_bank[1]);
      i_pmam_host.rd((k == 0) ? 8'h1c : 8'h1b, s);
      chk("rd_err", 8'h01, {7'h0, rd_err});
      chk("rd_data kept", em[4], rd_data);
    end
    phase <= 8'hff;
    $display("test refusals done");
    // random status against masks changed on the fly
    for (int n = 0; n < 30; n++) begin
      @(posedge mclk);
      status_bank <= (n == 0) ? '0 : {8'($urandom), 32'($urandom)} & {5{8'($urandom)}};
      v = 8'($urandom);
      i_pmam_host.wr(8'h1b, 8'(8'h7a + n % 5), v);
      em[n % 5] = v & wm[n % 5];
      @(posedge mclk);
      #1;
      chk("alert", {7'h0, exp_alert(status_bank, em)}, {7'h0, alert_n_oe});
      chk("alert data", 8'h00, {7'h0, alert_n_o});
    end
    $display("test alert gating done");
    // mid-run reset: masks clear at once, then every set status bit alerts
    @(posedge mclk);
    rst_b <= 1'b0;
    status_bank <= {5{8'h81}};
    em = '0;
    #1;
    for (int i = 0; i < 5; i++) begin
      chk("reset mask", 8'h00, mask_bank[i]);
    end
    chk("reset alert", 8'h00, {7'h0, alert_n_oe});
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk("alert after reset", {7'h0, exp_alert(status_bank, em)}, {7'h0, alert_n_oe});
    chk("rd_data after reset", 8'h00, rd_data);
    $display("test mid-run reset done");
    // enable low: the write is dropped and the status drop must wait
    clk_en <= 1'b0;
    status_bank <= '0;
    i_pmam_host.wr(8'h1b, 8'h7d, 8'hff);
    chk("frozen wr_done", 8'h00, {7'h0, wr_done});
    chk("frozen mask", em[3], mask_bank[3]);
    chk("frozen alert", 8'h01, {7'h0, alert_n_oe});
    clk_en <= 1'b1;
    @(posedge mclk);
    #1;
    chk("thawed alert", 8'h00, {7'h0, alert_n_oe});
    // a load in the same cycle beats the write; a same-cycle read sees the old byte
    nvm_bank <= '0;
    fork
      i_pmam_host.wr(8'h1b, 8'h7c, 8'hff);
      begin
        @(posedge mclk);
        nvm_load <= 1'b1;
        @(posedge mclk);
        nvm_load <= 1'b0;
      end
    join
    chk("lost write mask", em[2], mask_bank[2]);
    chk("lost wr_done", 8'h00, {7'h0, wr_done});
    fork
      i_pmam_host.wr(8'h1b, 8'h7e, 8'hff);
      i_pmam_host.rd(8'h1b, 8'h7e);
    join
    chk("same-cycle rd_data", em[4], rd_data);
    em[4] = 8'hff & wm[4];
    chk("same-cycle mask", em[4], mask_bank[4]);
    $display("test enable, load and overlap done");
    stop_test();
  end
endmodule
